//--- hw/ptc_pkg.sv
// Constants and types for the PCI target front end with EEPROM id loader.
// Assumes one clock and an asynchronous active-high reset everywhere.
package ptc_pkg;

  // ----------------------------------------------------------------
  // Bus commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_RD   = 4'h6;
  localparam logic [3:0] CMD_MEM_WR   = 4'h7;
  localparam logic [3:0] CMD_CFG_RD   = 4'hA;
  localparam logic [3:0] CMD_CFG_WR   = 4'hB;
  localparam logic [3:0] CMD_MEM_RDM  = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL  = 4'hE;
  localparam logic [3:0] CMD_MEM_WRI  = 4'hF;

  // ----------------------------------------------------------------
  // Configuration space offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_ID       = 8'h00;
  localparam logic [7:0]  CFG_CMDSTAT  = 8'h04;
  localparam logic [7:0]  CFG_CLASS    = 8'h08;
  localparam logic [7:0]  CFG_BAR      = 8'h10;
  localparam logic [7:0]  CFG_SUBSYS   = 8'h2C;
  localparam logic [7:0]  CFG_INTR     = 8'h3C;
  localparam int          CMD_MEM_BIT  = 1;
  localparam int          CMD_PERR_BIT = 6;
  localparam int          CMD_SERR_BIT = 8;
  localparam int          STAT_FB2B    = 23;
  localparam logic [23:0] CLASS_CODE   = 24'h070002;
  localparam logic [7:0]  REVISION_ID  = 8'h01;
  localparam logic [7:0]  INT_PIN      = 8'h01;
  localparam int          BAR_LSB      = 12;
  // Identity defaults, values are arbitrary
  localparam logic [15:0] VENDOR_DEF   = 16'h1D00;
  localparam logic [15:0] DEVICE_DEF   = 16'h0A01;

  // ----------------------------------------------------------------
  // Memory window offsets (byte addresses inside the 4K window)
  // ----------------------------------------------------------------
  localparam logic [11:0] MEM_INT_STAT = 12'h080;
  localparam logic [11:0] MEM_EE_MAN   = 12'h08C;
  localparam int          EE_CK_BIT    = 0;
  localparam int          EE_CS_BIT    = 1;
  localparam int          EE_DI_BIT    = 2;
  localparam int          EE_DO_BIT    = 3;
  localparam int          EE_BUSY_BIT  = 4;
  localparam int          INT_TIMER    = 8;
  localparam int          INT_MPIO     = 9;
  localparam int          INT_WAKE     = 10;

  // ----------------------------------------------------------------
  // EEPROM loader timing and framing
  // ----------------------------------------------------------------
  localparam int          EE_DIV       = 256;
  localparam logic [6:0]  EE_HALF_LAST = 7'(EE_DIV / 2 - 1);
  localparam logic [4:0]  EE_CMD_BITS  = 5'h09;
  localparam logic [4:0]  EE_DUMMY     = 5'h08;
  localparam logic [4:0]  EE_END       = 5'h19;
  localparam logic [1:0]  EE_LAST_WORD = 2'h3;
  localparam logic [2:0]  EE_RD_OP     = 3'h6;

  typedef enum logic [1:0] {
    PTC_IDLE = 2'b00,
    PTC_WAIT = 2'b01,
    PTC_DATA = 2'b10,
    PTC_TURN = 2'b11
  } ptc_bus_t;

  typedef enum logic [1:0] {
    PTC_LD_START = 2'b00,
    PTC_LD_RUN   = 2'b01,
    PTC_LD_GAP   = 2'b10,
    PTC_LD_DONE  = 2'b11
  } ptc_ld_t;

endpackage

//--- hw/ptc_ee_loader.sv
// Reads four 16-bit id words from a serial EEPROM after reset.
// Assumes a microwire-style part; read data idles high when none is fitted.
`timescale 1ns/10ps
module ptc_ee_loader (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        ee_rd,
  output logic             ee_ck,
  output logic             ee_cs,
  output logic             ee_di,
  output logic             busy,
  output logic [15:0]      vendor_id,
  output logic [15:0]      device_id,
  output logic [15:0]      sub_vendor_id,
  output logic [15:0]      sub_id
);

  typedef struct packed {
    ptc_pkg::ptc_ld_t  st;
    logic [6:0]        div;
    logic              ck;
    logic              cs;
    logic              di;
    logic [4:0]        bitn;
    logic [1:0]        word;
    logic [15:0]       sh;
    logic              ok;
    logic [3:0][15:0]  ids;
  } ptc_ld_state_t;

  ptc_ld_state_t s;
  ptc_ld_state_t next_s;
  logic [8:0]    cmd;

  // ----------------------------------------------------------------
  // Loader sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    cmd = {ptc_pkg::EE_RD_OP, 4'h0, s.word};
    next_s.div = s.div + 7'h01;
    if (s.div == ptc_pkg::EE_HALF_LAST) begin
      next_s.div = 7'h00;
      case (s.st)
        ptc_pkg::PTC_LD_START, ptc_pkg::PTC_LD_GAP: begin
          if (s.st == ptc_pkg::PTC_LD_GAP && s.word == ptc_pkg::EE_LAST_WORD) begin
            next_s.st = ptc_pkg::PTC_LD_DONE;
          end else begin
            if (s.st == ptc_pkg::PTC_LD_GAP) begin
              next_s.word = s.word + 2'h1;
            end
            next_s.cs = 1'b1;
            next_s.di = 1'b1;
            next_s.bitn = 5'h00;
            next_s.st = ptc_pkg::PTC_LD_RUN;
          end
        end
        ptc_pkg::PTC_LD_RUN: begin
          if (!s.ck) begin
            if (s.bitn == ptc_pkg::EE_END) begin
              next_s.cs = 1'b0;
              next_s.st = ptc_pkg::PTC_LD_GAP;
            end else begin
              next_s.ck = 1'b1;
            end
          end else begin
            next_s.ck = 1'b0;
            if (s.bitn == ptc_pkg::EE_DUMMY && ee_rd) begin
              next_s.ok = 1'b0;
            end
            if (s.bitn > ptc_pkg::EE_DUMMY) begin
              next_s.sh = {s.sh[14:0], ee_rd};
            end
            if (s.bitn == ptc_pkg::EE_END - 5'h01 && s.ok) begin
              next_s.ids[s.word] = {s.sh[14:0], ee_rd};
            end
            next_s.bitn = s.bitn + 5'h01;
            next_s.di = (s.bitn + 5'h01 < ptc_pkg::EE_CMD_BITS) ?
                        cmd[4'(ptc_pkg::EE_DUMMY - s.bitn - 5'h01)] : 1'b0;
          end
        end
        default: begin
          next_s.ck = 1'b0;
          next_s.cs = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{st: ptc_pkg::PTC_LD_START, div: 7'h00, ck: 1'b0, cs: 1'b0, di: 1'b0,
             bitn: 5'h00, word: 2'h0, sh: 16'h0000, ok: 1'b1,
             ids: {16'h0000, 16'h0000, ptc_pkg::DEVICE_DEF, ptc_pkg::VENDOR_DEF}};
    end else begin
      s <= next_s;
    end
  end

  assign ee_ck         = s.ck;
  assign ee_cs         = s.cs;
  assign ee_di         = s.di;
  assign busy          = (s.st != ptc_pkg::PTC_LD_DONE);
  assign vendor_id     = s.ids[0];
  assign device_id     = s.ids[1];
  assign sub_vendor_id = s.ids[2];
  assign sub_id        = s.ids[3];

endmodule

//--- hw/ptc_target.sv
// PCI target front end: config space, 4K memory window, id EEPROM.
// Assumes bus pins sampled on sys_clk; local register sets sit behind loc_*.
`timescale 1ns/10ps
module ptc_target (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  input  wire logic [3:0]  cbe_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        idsel,
  output logic             trdy_n,
  output logic             devsel_n,
  output logic             stop_n,
  output logic             ctl_oe,
  output logic             par_out,
  output logic             par_oe,
  output logic             eeprom_serial_clock,
  output logic             eeprom_chip_select,
  output logic             eeprom_write_data,
  input  wire logic        eeprom_read_data,
  input  wire logic [7:0]  irq_uart,
  input  wire logic        irq_timer,
  input  wire logic        irq_mpio,
  input  wire logic        irq_wake,
  output logic      [11:0] loc_addr,
  input  wire logic [31:0] loc_rdata,
  output logic             loc_wr,
  output logic      [11:0] loc_waddr,
  output logic      [31:0] loc_wdata,
  output logic      [3:0]  loc_be
);

  typedef struct packed {
    ptc_pkg::ptc_bus_t st;
    logic              busy;
    logic              mem;
    logic              wr;
    logic [9:0]        addr;
    logic [31:0]       ad_out;
    logic              ad_oe;
    logic              trdy_n;
    logic              devsel_n;
    logic              ctl_oe;
    logic              par;
    logic              par_oe;
    logic              mem_en;
    logic              perr_en;
    logic              serr_en;
    logic [19:0]       bar;
    logic [7:0]        int_line;
    logic [2:0]        man;
    logic              ee_ck;
    logic              ee_cs;
    logic              ee_di;
    logic              loc_wr;
    logic [11:0]       loc_waddr;
    logic [31:0]       loc_wdata;
    logic [3:0]        loc_be;
  } ptc_state_t;

  ptc_state_t  s;
  ptc_state_t  next_s;
  logic        ld_ck;
  logic        ld_cs;
  logic        ld_di;
  logic        ld_busy;
  logic [15:0] vendor_id;
  logic [15:0] device_id;
  logic [15:0] sub_vendor_id;
  logic [15:0] sub_id;
  logic [11:0] off;
  logic [31:0] rdata;
  logic [31:0] wmerge;
  logic [3:0]  be;
  logic        cfg_hit;
  logic        mem_hit;
  logic        is_mem_rd;
  logic        is_mem_wr;

  ptc_ee_loader u_loader (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .ee_rd         (eeprom_read_data),
    .ee_ck         (ld_ck),
    .ee_cs         (ld_cs),
    .ee_di         (ld_di),
    .busy          (ld_busy),
    .vendor_id     (vendor_id),
    .device_id     (device_id),
    .sub_vendor_id (sub_vendor_id),
    .sub_id        (sub_id)
  );

  // ----------------------------------------------------------------
  // Read data and byte lane merge
  // ----------------------------------------------------------------
  always_comb begin
    off = {s.addr, 2'b00};
    be = ~cbe_n;
    rdata = 32'h0000_0000;
    if (!s.mem) begin
      if (off[7:0] == ptc_pkg::CFG_ID) begin
        rdata = {device_id, vendor_id};
      end else if (off[7:0] == ptc_pkg::CFG_CMDSTAT) begin
        rdata[ptc_pkg::STAT_FB2B] = 1'b1;
        rdata[ptc_pkg::CMD_MEM_BIT] = s.mem_en;
        rdata[ptc_pkg::CMD_PERR_BIT] = s.perr_en;
        rdata[ptc_pkg::CMD_SERR_BIT] = s.serr_en;
      end else if (off[7:0] == ptc_pkg::CFG_CLASS) begin
        rdata = {ptc_pkg::CLASS_CODE, ptc_pkg::REVISION_ID};
      end else if (off[7:0] == ptc_pkg::CFG_BAR) begin
        rdata = {s.bar, 12'h000};
      end else if (off[7:0] == ptc_pkg::CFG_SUBSYS) begin
        rdata = {sub_id, sub_vendor_id};
      end else if (off[7:0] == ptc_pkg::CFG_INTR) begin
        rdata = {16'h0000, ptc_pkg::INT_PIN, s.int_line};
      end
    end else if (off == ptc_pkg::MEM_INT_STAT) begin
      rdata[7:0] = irq_uart;
      rdata[ptc_pkg::INT_TIMER] = irq_timer;
      rdata[ptc_pkg::INT_MPIO] = irq_mpio;
      rdata[ptc_pkg::INT_WAKE] = irq_wake;
    end else if (off == ptc_pkg::MEM_EE_MAN) begin
      rdata[ptc_pkg::EE_CK_BIT] = s.man[ptc_pkg::EE_CK_BIT];
      rdata[ptc_pkg::EE_CS_BIT] = s.man[ptc_pkg::EE_CS_BIT];
      rdata[ptc_pkg::EE_DI_BIT] = s.man[ptc_pkg::EE_DI_BIT];
      rdata[ptc_pkg::EE_DO_BIT] = eeprom_read_data;
      rdata[ptc_pkg::EE_BUSY_BIT] = ld_busy;
    end else begin
      rdata = loc_rdata;
    end
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = be[i] ? ad_in[i*8 +: 8] : rdata[i*8 +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    is_mem_rd = (cbe_n == ptc_pkg::CMD_MEM_RD) || (cbe_n == ptc_pkg::CMD_MEM_RDM) ||
                (cbe_n == ptc_pkg::CMD_MEM_RDL);
    is_mem_wr = (cbe_n == ptc_pkg::CMD_MEM_WR) || (cbe_n == ptc_pkg::CMD_MEM_WRI);
    cfg_hit = idsel && (ad_in[1:0] == 2'b00) &&
              ((cbe_n == ptc_pkg::CMD_CFG_RD) || (cbe_n == ptc_pkg::CMD_CFG_WR));
    mem_hit = s.mem_en && (ad_in[31:ptc_pkg::BAR_LSB] == s.bar) &&
              (is_mem_rd || is_mem_wr);
  end

  // ----------------------------------------------------------------
  // Target sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.loc_wr = 1'b0;
    next_s.par = ^{s.ad_out, cbe_n};
    next_s.par_oe = s.ad_oe;
    if (!frame_n) begin
      next_s.busy = 1'b1;
    end else if (irdy_n) begin
      next_s.busy = 1'b0;
    end
    case (s.st)
      ptc_pkg::PTC_IDLE: begin
        if (!frame_n && !s.busy && (cfg_hit || mem_hit)) begin
          next_s.mem = mem_hit && !cfg_hit;
          next_s.wr = cfg_hit ? cbe_n[0] : is_mem_wr;
          next_s.addr = ad_in[11:2];
          next_s.devsel_n = 1'b0;
          next_s.trdy_n = 1'b1;
          next_s.ctl_oe = 1'b1;
          next_s.st = (cfg_hit ? cbe_n[0] : is_mem_wr) ? ptc_pkg::PTC_DATA
                                                      : ptc_pkg::PTC_WAIT;
          next_s.trdy_n = !(cfg_hit ? cbe_n[0] : is_mem_wr);
        end
      end
      ptc_pkg::PTC_WAIT: begin
        next_s.ad_out = rdata;
        next_s.ad_oe = 1'b1;
        next_s.trdy_n = 1'b0;
        next_s.st = ptc_pkg::PTC_DATA;
      end
      ptc_pkg::PTC_DATA: begin
        if (!irdy_n) begin
          if (s.wr && !s.mem) begin
            if (off[7:0] == ptc_pkg::CFG_CMDSTAT) begin
              next_s.mem_en = wmerge[ptc_pkg::CMD_MEM_BIT];
              next_s.perr_en = wmerge[ptc_pkg::CMD_PERR_BIT];
              next_s.serr_en = wmerge[ptc_pkg::CMD_SERR_BIT];
            end else if (off[7:0] == ptc_pkg::CFG_BAR) begin
              next_s.bar = wmerge[31:ptc_pkg::BAR_LSB];
            end else if (off[7:0] == ptc_pkg::CFG_INTR) begin
              next_s.int_line = wmerge[7:0];
            end
          end else if (s.wr) begin
            if (off == ptc_pkg::MEM_EE_MAN) begin
              next_s.man = wmerge[2:0];
            end else if (off != ptc_pkg::MEM_INT_STAT) begin
              next_s.loc_wr = 1'b1;
              next_s.loc_waddr = off;
              next_s.loc_wdata = ad_in;
              next_s.loc_be = be;
            end
          end
          if (frame_n) begin
            next_s.devsel_n = 1'b1;
            next_s.trdy_n = 1'b1;
            next_s.ad_oe = 1'b0;
            next_s.st = ptc_pkg::PTC_TURN;
          end else begin
            next_s.addr = s.addr + 10'h001;
            next_s.trdy_n = !s.wr;
            next_s.st = s.wr ? ptc_pkg::PTC_DATA : ptc_pkg::PTC_WAIT;
          end
        end
      end
      default: begin
        next_s.ctl_oe = 1'b0;
        next_s.st = ptc_pkg::PTC_IDLE;
      end
    endcase
    next_s.ee_ck = ld_busy ? ld_ck : s.man[ptc_pkg::EE_CK_BIT];
    next_s.ee_cs = ld_busy ? ld_cs : s.man[ptc_pkg::EE_CS_BIT];
    next_s.ee_di = ld_busy ? ld_di : s.man[ptc_pkg::EE_DI_BIT];
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= ptc_pkg::PTC_IDLE;
      s.trdy_n <= 1'b1;
      s.devsel_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign ad_out              = s.ad_out;
  assign ad_oe               = s.ad_oe;
  assign trdy_n              = s.trdy_n;
  assign devsel_n            = s.devsel_n;
  assign stop_n              = s.ctl_oe | s.devsel_n;
  assign ctl_oe              = s.ctl_oe;
  assign par_out             = s.par;
  assign par_oe              = s.par_oe;
  assign eeprom_serial_clock = s.ee_ck;
  assign eeprom_chip_select  = s.ee_cs;
  assign eeprom_write_data   = s.ee_di;
  assign loc_addr            = {s.addr, 2'b00};
  assign loc_wr              = s.loc_wr;
  assign loc_waddr           = s.loc_waddr;
  assign loc_wdata           = s.loc_wdata;
  assign loc_be              = s.loc_be;

endmodule

//--- test/ptc_eeprom_model.sv
// Behavioural serial id EEPROM for the bench.
// Assumes the pin names of the target; read data has a pull-up.
`timescale 1ns/10ps
module ptc_eeprom_model #(
  parameter logic [63:0] WORDS = 64'h0
) (
  input  wire logic eeprom_serial_clock,
  input  wire logic eeprom_chip_select,
  input  wire logic eeprom_write_data,
  input  wire logic present,
  output logic      eeprom_read_data
);
  // ------------
  // Read sequencer
  // ------------
  logic [8:0]  cmd = 9'h000;
  logic [15:0] sh  = 16'h0000;
  logic        dout = 1'h1;
  int          cnt = 0;

  always @(posedge eeprom_serial_clock or negedge eeprom_chip_select) begin
    if (!eeprom_chip_select) begin
      cnt = 0;
      dout = 1'h1;
    end else begin
      if (cnt < 9) cmd = {cmd[7:0], eeprom_write_data};
      cnt++;
      if (cnt == 9 && cmd[8:6] == 3'h6) begin
        sh = WORDS[16 * cmd[1:0] +: 16];
        dout = 1'h0;
      end else if (cnt > 9 && cnt < 26 && cmd[8:6] == 3'h6) begin
        dout = sh[15];
        sh = {sh[14:0], 1'h1};
      end else if (cnt >= 26) begin
        dout = 1'h1;
      end
    end
  end

  assign eeprom_read_data = (present && eeprom_chip_select) ? dout : 1'h1;
endmodule

//--- test/ptc_target_properties.sv
// Port assertions for the PCI target front end.
// Assumes binding into ptc_target; one clock, async active-high reset.
`timescale 1ns/10ps
module ptc_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic [3:0]  cbe_n,
  input wire logic        trdy_n,
  input wire logic        devsel_n,
  input wire logic        stop_n,
  input wire logic        ctl_oe,
  input wire logic        par_out,
  input wire logic        par_oe,
  input wire logic        eeprom_serial_clock
);
  // ------------
  // Load phase flag
  // ------------
  logic loading;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loading <= 1'h1;
    end else if (!devsel_n) begin
      loading <= 1'h0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_devsel_drive: assert property (!devsel_n |-> ctl_oe)
    else $error("devsel low while not driven");
  chk_read_wait: assert property ($rose(ad_oe) |-> !trdy_n && $past(devsel_n) == 1'h0)
    else $error("read data without one wait");
  chk_no_stop: assert property (ctl_oe |-> stop_n)
    else $error("stop asserted");
  chk_trdy_claim: assert property (!trdy_n |-> !devsel_n)
    else $error("ready without claim");
  chk_release_order: assert property ($rose(devsel_n) |-> ctl_oe ##1 !ctl_oe)
    else $error("bad release order");
  chk_par_enable: assert property (par_oe == $past(ad_oe))
    else $error("parity enable not delayed");
  chk_par_value: assert property (par_oe |-> par_out == ^{$past(ad_out), $past(cbe_n)})
    else $error("parity wrong");
  chk_load_clock: assert property (loading && $rose(eeprom_serial_clock) |->
    ##128 $fell(eeprom_serial_clock)) else $error("load clock half period wrong");

  cover property ($rose(ad_oe));
  cover property (!devsel_n && !trdy_n && !ad_oe);
  cover property (loading && $fell(eeprom_serial_clock));
endmodule

bind ptc_target ptc_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .ad_out(ad_out),
  .ad_oe(ad_oe), .cbe_n(cbe_n), .trdy_n(trdy_n), .devsel_n(devsel_n), .stop_n(stop_n),
  .ctl_oe(ctl_oe), .par_out(par_out), .par_oe(par_oe),
  .eeprom_serial_clock(eeprom_serial_clock));

//--- test/testbench.sv
// Self-checking bench for the PCI target front end.
// Assumes the EEPROM model on the id pins and local read data made from loc_addr.
`timescale 1ns/10ps
module testbench;
  localparam logic [63:0] WORDS = 64'h4D2E_7B19_0C63_5A3C;
  logic        sys_clk = 1'h0, sys_rst = 1'h1, frame_n = 1'h1, irdy_n = 1'h1, idsel = 1'h0;
  logic        present = 1'h1, mon_on = 1'h1, ck, cs, di, dout, ad_oe, trdy_n, devsel_n;
  logic        loc_wr, irq_timer = 1'h0, irq_mpio = 1'h0, irq_wake = 1'h0;
  logic [31:0] ad_in = 32'h0, ad_out, loc_rdata, loc_wdata, last_rd, base;
  logic [3:0]  cbe_n = 4'hF, loc_be;
  logic [11:0] loc_addr, loc_waddr;
  logic [7:0]  irq_uart = 8'h00;
  logic [15:0] rnd = 16'hFE72;
  logic [47:0] notes[$];
  logic [3:0]  cmds[5] = '{ptc_pkg::CMD_MEM_RD, ptc_pkg::CMD_MEM_WR, ptc_pkg::CMD_MEM_RDM,
                           ptc_pkg::CMD_MEM_RDL, ptc_pkg::CMD_MEM_WRI};
  int          fail_count = 0, checks = 0;

  always #2 sys_clk = ~sys_clk;
  assign loc_rdata = {loc_addr, 8'hA5, loc_addr};

  ptc_target dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel),
    .trdy_n(trdy_n), .devsel_n(devsel_n), .stop_n(), .ctl_oe(), .par_out(), .par_oe(),
    .eeprom_serial_clock(ck), .eeprom_chip_select(cs), .eeprom_write_data(di),
    .eeprom_read_data(dout), .irq_uart(irq_uart), .irq_timer(irq_timer),
    .irq_mpio(irq_mpio), .irq_wake(irq_wake), .loc_addr(loc_addr), .loc_rdata(loc_rdata),
    .loc_wr(loc_wr), .loc_waddr(loc_waddr), .loc_wdata(loc_wdata), .loc_be(loc_be));
  ptc_eeprom_model #(.WORDS(WORDS)) u_ee (.eeprom_serial_clock(ck), .eeprom_chip_select(cs),
    .eeprom_write_data(di), .present(present), .eeprom_read_data(dout));

  // ------------
  // Helpers
  // ------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [47:0] rdn(input logic [11:0] a);
    return {16'h0000, a, 8'hA5, a};
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] a,
                      input int n, input logic [3:0] be, input logic [31:0] wd,
                      input logic claim);
    int   k;
    logic hit;
    hit = 1'h0;
    frame_n = 1'h0;
    idsel = sel;
    ad_in = a;
    cbe_n = cmd;
    @(posedge sys_clk);
    #1 idsel = 1'h0;
    for (int i = 0; i < n; i++) begin
      irdy_n = 1'h0;
      cbe_n = ~be;
      ad_in = wd + 32'(i);
      frame_n = (i == n - 1);
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
        hit = hit | (devsel_n === 1'h0);
        if (trdy_n === 1'h0) last_rd = ad_out;
      end while (trdy_n !== 1'h0 && k < 6);
      #1;
    end
    frame_n = 1'h1;
    irdy_n = 1'h1;
    chk(hit, claim);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] cmd, input logic sel, input logic [31:0] a,
                    input logic [47:0] e);
    notes.push_back(e);
    xfer(cmd, sel, a, 1, 4'hF, 32'h0, 1'h1);
  endtask

  task automatic boot(input logic p);
    present = p;
    sys_rst = 1'h1;
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'h0;
    repeat (20000) @(posedge sys_clk);
    #1;
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h10, 48'h0);
    xfer(ptc_pkg::CMD_MEM_RD, 1'h0, 32'h100, 1, 4'hF, 32'h0, 1'h0);
    rnd = lfsr(rnd);
    base = {rnd, 4'h3, 12'h000};
    xfer(ptc_pkg::CMD_CFG_WR, 1'h1, 32'h10, 1, 4'hF, base, 1'h1);
    xfer(ptc_pkg::CMD_CFG_WR, 1'h1, 32'h04, 1, 4'hF, 32'h2, 1'h1);
    mon_on = 1'h0;
    last_rd = 32'hFFFFFFFF;
    for (int i = 0; i < 60 && last_rd[4] !== 1'h0; i++) begin
      repeat (300) @(posedge sys_clk);
      #1 xfer(ptc_pkg::CMD_MEM_RD, 1'h0, base + 32'h08C, 1, 4'hF, 32'h0, 1'h1);
    end
    mon_on = 1'h1;
    chk(last_rd[4], 1'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------
  // Result watcher
  // ------------
  always @(posedge sys_clk) begin
    if (mon_on && ad_oe === 1'h1 && trdy_n === 1'h0 && irdy_n === 1'h0) begin
      chk({16'h0000, ad_out}, notes.size() != 0 ? notes.pop_front() : 48'hX);
    end
    if (loc_wr === 1'h1) begin
      chk({loc_be, loc_waddr, loc_wdata}, notes.size() != 0 ? notes.pop_front() : 48'hX);
    end
  end

  initial begin
    #380000;
    fail_count++;
    finish_test();
  end

  // ------------
  // Scenarios
  // ------------
  initial begin
    boot(1'h1);
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h00, {16'h0000, WORDS[31:0]});
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h2C, {16'h0000, WORDS[63:32]});
    xfer(ptc_pkg::CMD_CFG_WR, 1'h1, 32'h10, 1, 4'hF, 32'hFFFFFFFF, 1'h1);
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h10, 48'h0000FFFFF000);
    xfer(ptc_pkg::CMD_CFG_WR, 1'h1, 32'h10, 1, 4'h8, base, 1'h1);
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h10, {16'h0000, base[31:24], 24'hFFF000});
    xfer(ptc_pkg::CMD_CFG_WR, 1'h1, 32'h10, 1, 4'hF, base, 1'h1);
    $display("config test done");
    foreach (cmds[i]) begin
      rnd = lfsr(rnd);
      if (cmds[i][0]) begin
        notes.push_back({4'hF, 12'h200, 16'h0000, rnd});
        xfer(cmds[i], 1'h0, base + 32'h200, 1, 4'hF, {16'h0000, rnd}, 1'h1);
      end else begin
        rd(cmds[i], 1'h0, base + 32'h200, rdn(12'h200));
      end
    end
    for (int i = 0; i < 3; i++) begin
      notes.push_back({4'h6, 12'h100 + 12'(4 * i), {16'h0000, rnd} + 32'(i)});
    end
    xfer(ptc_pkg::CMD_MEM_WR, 1'h0, base + 32'h100, 3, 4'h6, {16'h0000, rnd}, 1'h1);
    notes.push_back(rdn(12'hFFC));
    notes.push_back(rdn(12'h000));
    xfer(ptc_pkg::CMD_MEM_RD, 1'h0, base + 32'hFFC, 2, 4'hF, 32'h0, 1'h1);
    xfer(ptc_pkg::CMD_MEM_RD, 1'h0, base + 32'h1000, 1, 4'hF, 32'h0, 1'h0);
    xfer(4'h2, 1'h0, base, 1, 4'hF, 32'h0, 1'h0);
    xfer(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h11, 1, 4'hF, 32'h0, 1'h0);
    $display("memory test done");
    rnd = lfsr(rnd);
    {irq_wake, irq_mpio, irq_timer, irq_uart} = rnd[10:0];
    rd(ptc_pkg::CMD_MEM_RD, 1'h0, base + 32'h080, {37'h0, rnd[10:0]});
    xfer(ptc_pkg::CMD_MEM_WR, 1'h0, base + 32'h080, 1, 4'hF, 32'hFFFFFFFF, 1'h1);
    xfer(ptc_pkg::CMD_MEM_WR, 1'h0, base + 32'h08C, 1, 4'hF, 32'h7, 1'h1);
    chk({ck, cs, di}, 3'h7);
    rd(ptc_pkg::CMD_MEM_RD, 1'h0, base + 32'h08C, 48'h00000000000F);
    xfer(ptc_pkg::CMD_MEM_WR, 1'h0, base + 32'h08C, 1, 4'hF, 32'h0, 1'h1);
    chk({ck, cs, di}, 3'h0);
    $display("status and manual test done");
    boot(1'h0);
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h00,
       {16'h0000, ptc_pkg::DEVICE_DEF, ptc_pkg::VENDOR_DEF});
    rd(ptc_pkg::CMD_CFG_RD, 1'h1, 32'h2C, 48'h0);
    $display("absent id test done");
    finish_test();
  end
endmodule
